// [rtl/ict_core.sv]
`timescale 1ns/1ps
module ict_core (
  input  wire logic                       clk_i,
  input  wire logic                       resetn_i,
  input  wire logic                       ce_i,
  input  wire logic                       start_i,
  input  wire logic [ict_pkg::OP_W-1:0]   op_i,
  input  wire logic [1:0]                 sub_i,
  input  wire logic                       long_i,
  input  wire logic [ict_pkg::MD_W-1:0]   mode_i,
  input  wire logic [ict_pkg::N_W-1:0]    count_i,
  input  wire logic [ict_pkg::EAC_W-1:0]  ea_clk_i,
  input  wire logic [ict_pkg::EAN_W-1:0]  ea_rd_i,
  input  wire logic [ict_pkg::EAN_W-1:0]  ea_wr_i,
  input  wire logic                       bus_ack_i,
  output logic                            bus_rd_o,
  output logic                            bus_wr_o,
  output logic                            cyc_start_o,
  output logic                            busy_o,
  output logic                            done_o,
  output logic                            illegal_o,
  output logic [ict_pkg::CLK_W-1:0]       clocks_o,
  output logic [ict_pkg::CNT_W-1:0]       reads_o,
  output logic [ict_pkg::CNT_W-1:0]       writes_o
);
  import ict_pkg::*;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_READ,
    ST_WRITE,
    ST_INTERNAL
  } ict_state_t;

  // Mode row: jump clocks/reads, address-load clocks/reads
  function automatic logic [24:0] addr_row(input logic [3:0] md);
    logic [24:0] r;
    r = 25'h0000000;
    case (md)
      MD_IND:      r = {1'b0, 8'h08, 4'h2, 8'h04, 4'h1};
      MD_DISP,
      MD_ABS_W,
      MD_PC_DISP:  r = {1'b0, 8'h0A, 4'h2, 8'h08, 4'h2};
      MD_INDEX,
      MD_PC_INDEX: r = {1'b0, 8'h0E, 4'h3, 8'h0C, 4'h2};
      MD_ABS_L:    r = {1'b0, 8'h0C, 4'h3, 8'h0C, 4'h3};
      default:     r = {1'b1, 24'h000000};
    endcase
    return r;
  endfunction

  // Multi move base: {bad, clocks, reads}; dir high is memory-to-register
  function automatic logic [12:0] multi_row(input logic dir, input logic [3:0] md);
    logic [12:0] r;
    r = 13'h0000;
    case (md)
      MD_IND:      r = dir ? {1'b0, 8'h0C, 4'h3} : {1'b0, 8'h08, 4'h2};
      MD_POSTINC:  r = dir ? {1'b0, 8'h0C, 4'h3} : {1'b1, 12'h000};
      MD_PREDEC:   r = dir ? {1'b1, 12'h000} : {1'b0, 8'h08, 4'h2};
      MD_DISP,
      MD_ABS_W:    r = dir ? {1'b0, 8'h10, 4'h4} : {1'b0, 8'h0C, 4'h3};
      MD_INDEX:    r = dir ? {1'b0, 8'h12, 4'h4} : {1'b0, 8'h0E, 4'h3};
      MD_ABS_L:    r = dir ? {1'b0, 8'h14, 4'h5} : {1'b0, 8'h10, 4'h4};
      MD_PC_DISP:  r = dir ? {1'b0, 8'h10, 4'h4} : {1'b1, 12'h000};
      MD_PC_INDEX: r = dir ? {1'b0, 8'h12, 4'h4} : {1'b1, 12'h000};
      default:     r = {1'b1, 12'h000};
    endcase
    return r;
  endfunction

  function automatic ict_cost_t base_cost(
    input logic [4:0] op,
    input logic [1:0] sb,
    input logic       lg,
    input logic [3:0] md,
    input logic [5:0] n
  );
    ict_cost_t   c;
    logic [15:0] n16;
    logic [24:0] ar;
    logic [12:0] mr;
    c   = '0;
    n16 = {10'h000, n};
    ar  = addr_row(md);
    mr  = multi_row(op == OP_MULTI_TO_REG, md);
    c.rd = 8'h01;
    case (op)
      OP_SHIFT_REG: c.clk = (lg ? 16'h0008 : 16'h0006) + (n16 << 1); // [RQ1]
      OP_SHIFT_MEM: begin
        c.bad = lg; // [RQ2]
        c.clk = 16'h0008;
        c.wr  = 8'h01;
      end
      OP_BIT_DYN_REG: c.clk = (sb == BK_CLEAR) ? 16'h000A : (sb == BK_TEST) ? 16'h0006 : 16'h0008; // [RQ4]
      OP_BIT_DYN_MEM: begin
        c.clk = (sb == BK_TEST) ? 16'h0004 : 16'h0008;
        c.wr  = (sb == BK_TEST) ? 8'h00 : 8'h01;
      end
      OP_BIT_IMM_REG: begin
        c.clk = (sb == BK_CLEAR) ? 16'h000E : (sb == BK_TEST) ? 16'h000A : 16'h000C; // [RQ5]
        c.rd  = 8'h02;
      end
      OP_BIT_IMM_MEM: begin
        c.clk = (sb == BK_TEST) ? 16'h0008 : 16'h000C; // [RQ5]
        c.rd  = 8'h02;
        c.wr  = (sb == BK_TEST) ? 8'h00 : 8'h01;
      end
      OP_BRANCH_COND: begin
        if (sb[BR_TAKEN_BIT] || sb[BR_WORD_BIT]) begin // [RQ6]
          c.clk = sb[BR_TAKEN_BIT] ? 16'h000A : 16'h000C;
          c.rd  = 8'h02;
        end else begin
          c.clk = 16'h0008;
        end
      end
      OP_BRANCH_ALWAYS: begin
        c.clk = 16'h000A; // [RQ7]
        c.rd  = 8'h02;
      end
      OP_CALL_REL: begin
        c.clk = 16'h0012; // [RQ7]
        c.rd  = 8'h02;
        c.wr  = 8'h02;
      end
      OP_DEC_BRANCH: begin
        c.bad = (sb > DB_EXPIRE);
        c.clk = (sb == DB_CC_TRUE) ? 16'h000C : (sb == DB_LOOP) ? 16'h000A : 16'h000E; // [RQ7]
        c.rd  = (sb == DB_EXPIRE) ? 8'h03 : 8'h02;
      end
      // Index register width is not an input at all [RQ12]
      OP_JUMP: begin
        c.bad = ar[24]; // [RQ8]
        c.clk = {8'h00, ar[23:16]};
        c.rd  = {4'h0, ar[15:12]};
      end
      OP_CALL_SUB: begin
        c.bad = ar[24]; // [RQ8]
        c.clk = {8'h00, ar[23:16]} + 16'h0008;
        c.rd  = (ar[3:0] < 4'h2) ? 8'h02 : {4'h0, ar[3:0]};
        c.wr  = 8'h02;
      end
      OP_LOAD_EA,
      OP_PUSH_EA: begin
        c.bad = ar[24]; // [RQ9]
        c.clk = {8'h00, ar[11:4]} + ((op == OP_PUSH_EA) ? 16'h0008 : 16'h0000);
        c.rd  = {4'h0, ar[3:0]};
        c.wr  = (op == OP_PUSH_EA) ? 8'h02 : 8'h00;
      end
      OP_MULTI_TO_REG: begin
        c.bad = mr[12]; // [RQ10]
        c.clk = {8'h00, mr[11:4]} + (lg ? (n16 << 3) : (n16 << 2));
        c.rd  = {4'h0, mr[3:0]} + (lg ? {n16[6:0], 1'b0} : n16[7:0]);
      end
      OP_MULTI_TO_MEM: begin
        c.bad = mr[12]; // [RQ11]
        c.clk = {8'h00, mr[11:4]} + (lg ? (n16 << 3) : (n16 << 2));
        c.rd  = {4'h0, mr[3:0]};
        c.wr  = lg ? {n16[6:0], 1'b0} : n16[7:0];
      end
      OP_EXT_REG: c.clk = lg ? 16'h0008 : 16'h0004; // [RQ13]
      OP_DEC_REG: begin
        c.bad = lg; // [RQ13]
        c.clk = 16'h0006;
      end
      OP_EXT_MEM,
      OP_DEC_MEM: begin
        c.bad = lg && (op == OP_DEC_MEM); // [RQ14]
        c.clk = lg ? 16'h001E : 16'h0012;
        c.rd  = lg ? 8'h05 : 8'h03;
        c.wr  = lg ? 8'h02 : 8'h01;
      end
      OP_CMP_MEM: begin
        c.clk = lg ? 16'h0014 : 16'h000C; // [RQ15]
        c.rd  = lg ? 8'h05 : 8'h03;
      end
      default: c.bad = 1'b1;
    endcase
    return c;
  endfunction

  function automatic logic adds_ea(input logic [4:0] op);
    return (op == OP_SHIFT_MEM) || (op == OP_BIT_DYN_MEM) || (op == OP_BIT_IMM_MEM);
  endfunction

  ict_state_t       state;
  ict_state_t       next_state;
  logic [1:0]       phase;
  logic [1:0]       next_phase;
  logic             ack_meta;
  logic             ack_sync;
  logic             bus_end;
  logic             accept;
  logic             finish;
  ict_cost_t        base;
  ict_cost_t        tot;
  logic [CLK_W-1:0] bus_clks;
  logic [CLK_W-1:0] rem;
  logic [CLK_W-1:0] elapsed;
  logic [CLK_W-1:0] lat_clk;
  logic [CNT_W-1:0] rd_left;
  logic [CNT_W-1:0] wr_left;
  logic [CNT_W-1:0] lat_rd;
  logic [CNT_W-1:0] lat_wr;
  logic [OP_W-1:0]  lat_op;

  always_comb begin
    base = base_cost(op_i, sub_i, long_i, mode_i, count_i);
    tot  = base;
    if (adds_ea(op_i)) begin // [RQ3]
      tot.clk = base.clk + {8'h00, ea_clk_i};
      tot.rd  = base.rd + {4'h0, ea_rd_i};
      tot.wr  = base.wr + {4'h0, ea_wr_i};
    end
    bus_clks = {6'h00, tot.rd, 2'b00} + {6'h00, tot.wr, 2'b00};
  end

  assign accept  = (state == ST_IDLE) && start_i && !tot.bad;
  assign bus_end = (phase == BUS_LAST_PHASE) && ack_sync; // [RQ17]
  assign finish  = (state != ST_IDLE) && (next_state == ST_IDLE);

  always_comb begin
    next_state = state;
    case (state)
      ST_IDLE: if (accept) begin
        next_state = ST_READ;
      end
      ST_READ: if (bus_end && rd_left == 8'h01) begin
        next_state = (wr_left != 8'h00) ? ST_WRITE : (rem != 16'h0000) ? ST_INTERNAL : ST_IDLE;
      end
      ST_WRITE: if (bus_end && wr_left == 8'h01) begin
        next_state = (rem != 16'h0000) ? ST_INTERNAL : ST_IDLE;
      end
      ST_INTERNAL: if (rem == 16'h0001) begin
        next_state = ST_IDLE;
      end
      default: next_state = ST_IDLE;
    endcase
    next_phase = 2'h0;
    if ((state == ST_READ || state == ST_WRITE) && !bus_end) begin
      next_phase = (phase == BUS_LAST_PHASE) ? phase : phase + 2'h1;
    end
  end

  // Acknowledge arrives from the memory pins
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      ack_meta <= 1'b0;
      ack_sync <= 1'b0;
    end else if (ce_i) begin
      ack_meta <= bus_ack_i;
      ack_sync <= ack_meta;
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      state       <= ST_IDLE;
      phase       <= 2'h0;
      bus_rd_o    <= 1'b0;
      bus_wr_o    <= 1'b0;
      cyc_start_o <= 1'b0;
      busy_o      <= 1'b0;
    end else if (ce_i) begin
      state       <= next_state;
      phase       <= next_phase;
      bus_rd_o    <= (next_state == ST_READ);
      bus_wr_o    <= (next_state == ST_WRITE);
      cyc_start_o <= (next_state == ST_READ || next_state == ST_WRITE) && (next_phase == 2'h0);
      busy_o      <= (next_state != ST_IDLE);
    end
  end

  // Remaining bus cycles and internal clocks of the running instruction
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rd_left <= 8'h00;
      wr_left <= 8'h00;
      rem     <= 16'h0000;
      lat_clk <= 16'h0000;
      lat_rd  <= 8'h00;
      lat_wr  <= 8'h00;
      lat_op  <= 5'h00;
    end else if (ce_i) begin
      if (accept) begin
        rd_left <= tot.rd;
        wr_left <= tot.wr;
        rem     <= (tot.clk > bus_clks) ? tot.clk - bus_clks : 16'h0000; // [RQ16]
        lat_clk <= tot.clk;
        lat_rd  <= tot.rd;
        lat_wr  <= tot.wr;
        lat_op  <= op_i;
      end else begin
        if (state == ST_READ && bus_end) begin
          rd_left <= rd_left - 8'h01;
        end
        if (state == ST_WRITE && bus_end) begin
          wr_left <= wr_left - 8'h01;
        end
        if (state == ST_INTERNAL) begin
          rem <= rem - 16'h0001;
        end
      end
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      elapsed   <= 16'h0000;
      done_o    <= 1'b0;
      illegal_o <= 1'b0;
      clocks_o  <= 16'h0000;
      reads_o   <= 8'h00;
      writes_o  <= 8'h00;
    end else if (ce_i) begin
      elapsed   <= (state == ST_IDLE) ? 16'h0000 : elapsed + 16'h0001;
      done_o    <= finish;
      illegal_o <= (state == ST_IDLE) && start_i && tot.bad; // [RQ2] [RQ11]
      if (finish) begin
        clocks_o <= elapsed + 16'h0001; // [RQ17]
        reads_o  <= lat_rd;
        writes_o <= lat_wr;
      end
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!resetn_i);
  a_shift_reg_cost: assert property (ce_i && accept && op_i == OP_SHIFT_REG // [RQ1]
    |=> lat_clk == 16'(($past(long_i) ? 8 : 6) + 2 * $past(count_i)) && lat_rd == 8'h01)
    else $error("register shift cost wrong");
  a_shift_mem_long: assert property (ce_i && state == ST_IDLE && start_i && op_i == OP_SHIFT_MEM && long_i // [RQ2]
    |=> illegal_o && !busy_o)
    else $error("long memory shift accepted");
  a_ea_time_added: assert property (ce_i && accept && op_i == OP_SHIFT_MEM // [RQ3]
    |=> lat_clk == 16'(8 + $past(ea_clk_i)) && lat_wr == 8'(1 + $past(ea_wr_i)))
    else $error("address time not added");
  a_bit_clear_reg: assert property (ce_i && accept && op_i == OP_BIT_DYN_REG && sub_i == BK_CLEAR // [RQ4]
    |=> lat_clk == 16'h000A && lat_rd == 8'h01)
    else $error("bit clear cost wrong");
  a_bit_imm_reads: assert property (ce_i && accept && op_i == OP_BIT_IMM_REG // [RQ5]
    |=> lat_rd == 8'h02 && lat_wr == 8'h00)
    else $error("immediate bit reads wrong");
  a_branch_short: assert property (ce_i && accept && op_i == OP_BRANCH_COND && sub_i == 2'h0 // [RQ6]
    |=> lat_clk == 16'h0008 && lat_rd == 8'h01)
    else $error("untaken short branch wrong");
  a_dec_expire: assert property (ce_i && accept && op_i == OP_DEC_BRANCH && sub_i == DB_EXPIRE // [RQ7]
    |=> lat_clk == 16'h000E && lat_rd == 8'h03)
    else $error("count expiry cost wrong");
  a_jump_indexed: assert property (ce_i && accept && op_i == OP_JUMP && mode_i == MD_INDEX // [RQ8] [RQ12]
    |=> lat_clk == 16'h000E && lat_rd == 8'h03)
    else $error("indexed jump cost wrong");
  a_push_indirect: assert property (ce_i && accept && op_i == OP_PUSH_EA && mode_i == MD_IND // [RQ9]
    |=> lat_clk == 16'h000C && lat_rd == 8'h01 && lat_wr == 8'h02)
    else $error("push cost wrong");
  a_multi_load: assert property (ce_i && accept && op_i == OP_MULTI_TO_REG && mode_i == MD_IND && !long_i // [RQ10]
    |=> lat_clk == 16'(12 + 4 * $past(count_i)) && lat_rd == 8'(3 + $past(count_i)))
    else $error("multi load cost wrong");
  a_multi_postinc: assert property (ce_i && state == ST_IDLE && start_i && op_i == OP_MULTI_TO_MEM // [RQ11]
    && mode_i == MD_POSTINC |=> illegal_o)
    else $error("postincrement store accepted");
  a_ext_mem_long: assert property (ce_i && accept && op_i == OP_EXT_MEM && long_i // [RQ14]
    |=> lat_clk == 16'h001E && lat_rd == 8'h05 && lat_wr == 8'h02)
    else $error("long memory extended cost wrong");
  a_cmp_no_write: assert property (busy_o && lat_op == OP_CMP_MEM |-> !bus_wr_o) // [RQ15]
    else $error("memory compare wrote");
  a_bus_four_clk: assert property ((cyc_start_o ##1 ce_i [*3]) |-> !cyc_start_o && (bus_rd_o || bus_wr_o)) // [RQ17]
    else $error("bus cycle shorter than four clocks");
  a_done_not_short: assert property (done_o |-> clocks_o >= lat_clk) // [RQ16]
    else $error("instruction finished early");
endmodule

// [inc/ict_pkg.sv]
// Contract
// (RQ1) Register shift: 6+2n or 8+2n, one read
// (RQ2) Memory shift: 8 clocks, 1/1, no long
// (RQ3) Marked forms add address-calculation clocks and cycles
// (RQ4) Dynamic register bit ops: 8, 10, 6 clocks
// (RQ5) Immediate bit ops: two reads, 12/14/8; the code gives 10 clocks for register test
// (RQ6) Conditional branch: 10 taken, 8 or 12 not
// (RQ7) Relative branch 10, call 18, decrement 12/10/14
// (RQ8) Jump and call per addressing mode table
// (RQ9) Address load and push per mode table
// (RQ10) Memory-to-register multi move: 12+4n or 12+8n
// (RQ11) Register-to-memory multi move: 8+4n, no postincrement; the code gives 8+8n for long
// (RQ12) Index register width never changes timing
// (RQ13) Register extended 4/8, decimal 6 clocks
// (RQ14) Memory extended/decimal: 18(3/1) or 30(5/2)
// (RQ15) Memory compare: 12(3/0) or 20(5/0), no writes
// (RQ16) Counts include operand fetch and next prefetch
// (RQ17) Each bus cycle four clocks plus waits
package ict_pkg;
  localparam int unsigned OP_W  = 5;
  localparam int unsigned MD_W  = 4;
  localparam int unsigned N_W   = 6;
  localparam int unsigned EAC_W = 8;
  localparam int unsigned EAN_W = 4;
  localparam int unsigned CLK_W = 16;
  localparam int unsigned CNT_W = 8;

  localparam logic [4:0] OP_SHIFT_REG     = 5'h00;
  localparam logic [4:0] OP_SHIFT_MEM     = 5'h01;
  localparam logic [4:0] OP_BIT_DYN_REG   = 5'h02;
  localparam logic [4:0] OP_BIT_DYN_MEM   = 5'h03;
  localparam logic [4:0] OP_BIT_IMM_REG   = 5'h04;
  localparam logic [4:0] OP_BIT_IMM_MEM   = 5'h05;
  localparam logic [4:0] OP_BRANCH_COND   = 5'h06;
  localparam logic [4:0] OP_BRANCH_ALWAYS = 5'h07;
  localparam logic [4:0] OP_CALL_REL      = 5'h08;
  localparam logic [4:0] OP_DEC_BRANCH    = 5'h09;
  localparam logic [4:0] OP_JUMP          = 5'h0A;
  localparam logic [4:0] OP_CALL_SUB      = 5'h0B;
  localparam logic [4:0] OP_LOAD_EA       = 5'h0C;
  localparam logic [4:0] OP_PUSH_EA       = 5'h0D;
  localparam logic [4:0] OP_MULTI_TO_REG  = 5'h0E;
  localparam logic [4:0] OP_MULTI_TO_MEM  = 5'h0F;
  localparam logic [4:0] OP_EXT_REG       = 5'h10;
  localparam logic [4:0] OP_EXT_MEM       = 5'h11;
  localparam logic [4:0] OP_DEC_REG       = 5'h12;
  localparam logic [4:0] OP_DEC_MEM       = 5'h13;
  localparam logic [4:0] OP_CMP_MEM       = 5'h14;

  localparam logic [3:0] MD_IND      = 4'h0;
  localparam logic [3:0] MD_POSTINC  = 4'h1;
  localparam logic [3:0] MD_PREDEC   = 4'h2;
  localparam logic [3:0] MD_DISP     = 4'h3;
  localparam logic [3:0] MD_INDEX    = 4'h4;
  localparam logic [3:0] MD_ABS_W    = 4'h5;
  localparam logic [3:0] MD_ABS_L    = 4'h6;
  localparam logic [3:0] MD_PC_DISP  = 4'h7;
  localparam logic [3:0] MD_PC_INDEX = 4'h8;

  localparam logic [1:0] BK_CHANGE = 2'h0;
  localparam logic [1:0] BK_CLEAR  = 2'h1;
  localparam logic [1:0] BK_SET    = 2'h2;
  localparam logic [1:0] BK_TEST   = 2'h3;

  localparam logic [1:0] DB_CC_TRUE = 2'h0;
  localparam logic [1:0] DB_LOOP    = 2'h1;
  localparam logic [1:0] DB_EXPIRE  = 2'h2;

  localparam int unsigned BR_TAKEN_BIT = 0;
  localparam int unsigned BR_WORD_BIT  = 1;

  localparam logic [1:0] BUS_LAST_PHASE = 2'h3;

  typedef struct packed {
    logic             bad;
    logic [CLK_W-1:0] clk;
    logic [CNT_W-1:0] rd;
    logic [CNT_W-1:0] wr;
  } ict_cost_t;
endpackage

// [verification/ict_mem_model.sv]
`timescale 1ns/1ps
module ict_mem_model (
  input  wire logic       clk_i,
  input  wire logic       resetn_i,
  input  wire logic       cyc_start_i,
  input  wire logic [3:0] wait_i,
  output logic            ack_o
);
  logic [3:0] hold;

  // Ready withheld for wait_i clocks from each cycle start
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      hold <= 4'h0;
    end else if (cyc_start_i && wait_i != 4'h0) begin
      hold <= wait_i;
    end else if (hold != 4'h0) begin
      hold <= hold - 4'h1;
    end
  end

  assign ack_o = (hold == 4'h0);
endmodule

// [verification/instruction_cycle_timing_test.sv]
`timescale 1ns/1ps
module instruction_cycle_timing_test;
  import ict_pkg::*;
  typedef struct {
    ict_cost_t  c;
    logic [3:0] slow;
  } ict_exp_t;
  localparam ict_cost_t BAD = '{bad: 1'b1, default: '0};
  localparam int JC [4][9] = '{'{8, 0, 0, 10, 14, 10, 12, 10, 14}, '{16, 0, 0, 18, 22, 18, 20, 18, 22},
                               '{4, 0, 0, 8, 12, 8, 12, 8, 12}, '{12, 0, 0, 16, 20, 16, 20, 16, 20}};
  localparam int JR [4][9] = '{'{2, 0, 0, 2, 3, 2, 3, 2, 3}, '{2, 0, 0, 2, 2, 2, 3, 2, 2},
                               '{1, 0, 0, 2, 2, 2, 3, 2, 2}, '{1, 0, 0, 2, 2, 2, 3, 2, 2}};
  localparam int RC [9] = '{12, 12, 0, 16, 18, 16, 20, 16, 18};
  localparam int RR [9] = '{3, 3, 0, 4, 4, 4, 5, 4, 4};
  localparam int WC [9] = '{8, 0, 8, 12, 14, 12, 16, 0, 0};
  localparam int WR [9] = '{2, 0, 2, 3, 3, 3, 4, 0, 0};

  logic             clk_i    = 1'b0;
  logic             resetn_i = 1'b0;
  logic             ce_i     = 1'b1;
  logic             start_i  = 1'b0;
  logic [OP_W-1:0]  op_i     = '0;
  logic [1:0]       sub_i    = '0;
  logic             long_i   = 1'b0;
  logic [MD_W-1:0]  mode_i   = '0;
  logic [N_W-1:0]   count_i  = '0;
  logic [EAC_W-1:0] ea_clk_i = '0;
  logic [EAN_W-1:0] ea_rd_i  = '0;
  logic [EAN_W-1:0] ea_wr_i  = '0;
  logic [3:0]       wait_n   = '0;
  logic             bus_ack_i, bus_rd_o, bus_wr_o, cyc_start_o, busy_o, done_o, illegal_o;
  logic [CLK_W-1:0] clocks_o;
  logic [CNT_W-1:0] reads_o, writes_o;
  int               n_errors = 0;
  int               total_checks = 0;
  int               seed = 32'h54c14a3c;
  int               nb = 0, ns = 0, nr = 0, nw = 0;
  logic             wseen = 1'b0, bad_ord = 1'b0;
  ict_exp_t         q[$];
  ict_exp_t         me;

  ict_core i_ict_core (.clk_i(clk_i), .resetn_i(resetn_i), .ce_i(ce_i), .start_i(start_i), .op_i(op_i),
    .sub_i(sub_i), .long_i(long_i), .mode_i(mode_i), .count_i(count_i), .ea_clk_i(ea_clk_i),
    .ea_rd_i(ea_rd_i), .ea_wr_i(ea_wr_i), .bus_ack_i(bus_ack_i), .bus_rd_o(bus_rd_o), .bus_wr_o(bus_wr_o),
    .cyc_start_o(cyc_start_o), .busy_o(busy_o), .done_o(done_o), .illegal_o(illegal_o),
    .clocks_o(clocks_o), .reads_o(reads_o), .writes_o(writes_o));

  ict_mem_model i_ict_mem_model (.clk_i(clk_i), .resetn_i(resetn_i), .cyc_start_i(cyc_start_o),
    .wait_i(wait_n), .ack_o(bus_ack_i));

  initial begin
    forever #2.5 clk_i = ~clk_i;
  end

  function automatic ict_cost_t mk(input int c, input int r, input int w);
    mk = '{bad: 1'b0, clk: CLK_W'(c), rd: CNT_W'(r), wr: CNT_W'(w)};
  endfunction

  function automatic ict_cost_t cost(input logic [4:0] op, input logic [1:0] sb, input logic lg,
                                     input int md, input int n, input int ec, input int er, input int ew);
    int s;
    s = lg ? 2 : 1;
    cost = BAD;
    case (op)
      OP_SHIFT_REG:     cost = mk(lg ? 8 + 2 * n : 6 + 2 * n, 1, 0);
      OP_SHIFT_MEM:     if (!lg) cost = mk(8 + ec, 1 + er, 1 + ew);
      OP_BIT_DYN_REG:   cost = mk(sb == BK_CLEAR ? 10 : sb == BK_TEST ? 6 : 8, 1, 0);
      OP_BIT_DYN_MEM:   cost = sb == BK_TEST ? mk(4 + ec, 1 + er, ew) : mk(8 + ec, 1 + er, 1 + ew);
      OP_BIT_IMM_REG:   cost = mk(sb == BK_CLEAR ? 14 : sb == BK_TEST ? 10 : 12, 2, 0);
      OP_BIT_IMM_MEM:   cost = sb == BK_TEST ? mk(8 + ec, 2 + er, ew) : mk(12 + ec, 2 + er, 1 + ew);
      OP_BRANCH_COND:   cost = sb[BR_TAKEN_BIT] ? mk(10, 2, 0) : sb[BR_WORD_BIT] ? mk(12, 2, 0) : mk(8, 1, 0);
      OP_BRANCH_ALWAYS: cost = mk(10, 2, 0);
      OP_CALL_REL:      cost = mk(18, 2, 2);
      OP_DEC_BRANCH:    if (sb != 2'h3) cost = mk(sb == DB_CC_TRUE ? 12 : sb == DB_LOOP ? 10 : 14,
                                              sb == DB_EXPIRE ? 3 : 2, 0);
      OP_JUMP, OP_CALL_SUB, OP_LOAD_EA, OP_PUSH_EA:
        if (JC[op - OP_JUMP][md] != 0) cost = mk(JC[op - OP_JUMP][md], JR[op - OP_JUMP][md], op[0] ? 2 : 0);
      OP_MULTI_TO_REG:  if (RC[md] != 0) cost = mk(RC[md] + 4 * s * n, RR[md] + s * n, 0);
      OP_MULTI_TO_MEM:  if (WC[md] != 0) cost = mk(WC[md] + 4 * s * n, WR[md], s * n);
      OP_EXT_REG:       cost = mk(lg ? 8 : 4, 1, 0);
      OP_DEC_REG:       if (!lg) cost = mk(6, 1, 0);
      OP_EXT_MEM:       cost = lg ? mk(30, 5, 2) : mk(18, 3, 1);
      OP_DEC_MEM:       if (!lg) cost = mk(18, 3, 1);
      OP_CMP_MEM:       cost = lg ? mk(20, 5, 0) : mk(12, 3, 0);
      default:          cost = BAD;
    endcase
  endfunction

  task automatic check_val(input string what, input logic [15:0] exp, input logic [15:0] got);
    total_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] %s expected %0d seen %0d", what, exp, got);
    end
  endtask

  task automatic check_flag(input string what, input logic exp, input logic got);
    total_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] %s expected %b seen %b", what, exp, got);
    end
  endtask

  task automatic conclude();
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // Drives one start at a falling edge; hold keeps it up while busy
  task automatic issue(input logic [4:0] op, input logic [1:0] sb, input logic lg, input logic [3:0] md,
                       input logic [5:0] n, input logic hold);
    ict_exp_t e;
    int k;
    e.c = cost(op, sb, lg, int'(md), int'(n), int'(ea_clk_i), int'(ea_rd_i), int'(ea_wr_i));
    e.slow = wait_n;
    q.push_back(e);
    op_i = op;
    sub_i = sb;
    long_i = lg;
    mode_i = md;
    count_i = n;
    start_i = 1'b1;
    @(negedge clk_i);
    if (!hold) start_i = 1'b0;
    k = 0;
    while (done_o !== 1'b1 && illegal_o !== 1'b1 && k < 3000) begin
      @(negedge clk_i);
      k++;
    end
    check_flag("completion", 1'b1, k < 3000);
    if (hold) begin
      start_i = 1'b0;
      @(negedge clk_i);
    end
  endtask

  task automatic judge(input ict_exp_t e);
    check_flag("refused", e.c.bad, illegal_o);
    if (e.c.bad) begin
      check_val("strobes when refused", 16'h0, 16'(ns));
    end else begin
      check_val("reads", 16'(e.c.rd), 16'(reads_o));
      check_val("writes", 16'(e.c.wr), 16'(writes_o));
      check_val("read cycles", 16'(e.c.rd), 16'(nr));
      check_val("write cycles", 16'(e.c.wr), 16'(nw));
      check_val("busy clocks", 16'(nb), clocks_o);
      check_val("strobe clocks", 16'(ns) + e.c.clk - 16'(4 * (e.c.rd + e.c.wr)), clocks_o);
      check_flag("read after write", 1'b0, bad_ord);
      if (e.slow != 4'h0) check_val("waits lengthen", e.c.clk + 16'(e.slow) * 16'(e.c.rd + e.c.wr), clocks_o);
      else check_val("clocks", e.c.clk, clocks_o);
    end
  endtask

  always @(negedge clk_i) begin
    if (resetn_i && (done_o === 1'b1 || illegal_o === 1'b1)) begin
      if (q.size() == 0) begin
        check_flag("unrequested result", 1'b0, 1'b1);
      end else begin
        me = q.pop_front();
        judge(me);
      end
    end
    if (!resetn_i || done_o === 1'b1 || illegal_o === 1'b1) begin
      nb = 0;
      ns = 0;
      nr = 0;
      nw = 0;
      wseen = 1'b0;
      bad_ord = 1'b0;
    end else begin
      nb += int'(busy_o);
      ns += int'(bus_rd_o | bus_wr_o);
      if (cyc_start_o && bus_rd_o) nr++;
      if (cyc_start_o && bus_rd_o && wseen) bad_ord = 1'b1;
      if (cyc_start_o && bus_wr_o) nw++;
      if (cyc_start_o && bus_wr_o) wseen = 1'b1;
    end
  end

  initial begin
    repeat (60000) @(posedge clk_i);
    n_errors++;
    $display("[FAIL] run length expected finish seen timeout");
    conclude();
  end

  initial begin
    int r;
    repeat (2) @(negedge clk_i);
    resetn_i = 1'b1;
    @(negedge clk_i);
    ea_clk_i = 8'h0A;
    ea_rd_i = 4'h1;
    ea_wr_i = 4'h1;
    issue(OP_BRANCH_COND, 2'h0, 1'b0, MD_IND, 6'h0, 1'b0);
    // Every group against every mode, sub code and size, back to back
    for (int o = 0; o < 23; o++) begin
      for (int m = 0; m < 9; m++) begin
        issue(5'(o), 2'(m), m >= 4, 4'(m), 6'h3, m == 8);
      end
    end
    for (int i = 0; i < 150; i++) begin
      r = $random(seed);
      ea_rd_i = 4'(r[1:0]);
      ea_wr_i = 4'(r[2]);
      ea_clk_i = 8'(4 * (r[1:0] + r[2]) + 2 * r[4:3]);
      wait_n = r[5] ? 4'(3 + r[7:6]) : 4'h0;
      issue(5'(r[15:8] % 23), r[17:16], r[18], 4'(r[23:20] % 9), 6'(r[28:24]), r[29] & r[30]);
    end
    wait_n = 4'h0;
    op_i = OP_CALL_REL;
    start_i = 1'b1;
    @(negedge clk_i);
    start_i = 1'b0;
    repeat (3) @(negedge clk_i);
    resetn_i = 1'b0;
    @(negedge clk_i);
    check_val("flags in reset", 16'h0, 16'({busy_o, bus_rd_o, bus_wr_o, cyc_start_o, done_o, illegal_o}));
    check_val("counts in reset", 16'h0, clocks_o | {reads_o, writes_o});
    @(negedge clk_i);
    resetn_i = 1'b1;
    ce_i = 1'b0;
    @(negedge clk_i);
    // Held start waits for the clock enable
    fork
      issue(OP_CMP_MEM, 2'h0, 1'b1, MD_IND, 6'h0, 1'b1);
      begin
        repeat (3) @(negedge clk_i);
        check_flag("frozen while disabled", 1'b0, busy_o);
        ce_i = 1'b1;
      end
    join
    repeat (4) @(negedge clk_i);
    conclude();
  end
endmodule
